/* verilog/irq_pkg.sv */
/*
 * constants, register map, field layouts and carrier types of the interrupt
 * controller slice with shadow context storage and external edge requests.
 * assumes a single core clock and a synchronous active-low reset.
 */
package irq_pkg;
    localparam int NUM_REGS = 20;
    localparam int NUM_SRC = 48;             // three flag words of sources
    // register offsets, as printed
    localparam logic [15:0] OFS_CTRL_TWO = 16'h0082;
    localparam logic [15:0] OFS_FLAGS_0 = 16'h0084;
    localparam logic [15:0] OFS_FLAGS_1 = 16'h0086;
    localparam logic [15:0] OFS_FLAGS_2 = 16'h0088;
    localparam logic [15:0] OFS_EN_0 = 16'h008C;
    localparam logic [15:0] OFS_EN_1 = 16'h3800;
    localparam logic [15:0] OFS_EN_2 = 16'h0600;
    localparam logic [15:0] OFS_CTRL_ONE = 16'h0800;
    localparam logic [15:0] OFS_PRI_0 = 16'h0094;
    localparam logic [15:0] OFS_PRI_1 = 16'h9600;
    localparam logic [15:0] OFS_PRI_2 = 16'h8600;
    localparam logic [15:0] OFS_PRI_3 = 16'hA600;
    localparam logic [15:0] OFS_PRI_4 = 16'h009C;
    localparam logic [15:0] OFS_PRI_5 = 16'h009E;
    localparam logic [15:0] OFS_PRI_6 = 16'h00A0;
    localparam logic [15:0] OFS_PRI_7 = 16'h00A2;
    localparam logic [15:0] OFS_PRI_8 = 16'h00A4;
    localparam logic [15:0] OFS_PRI_9 = 16'h00A6;
    localparam logic [15:0] OFS_PRI_10 = 16'h00A8;
    localparam logic [15:0] OFS_PRI_11 = 16'h00AA;
    // own registers: event status and mask
    localparam logic [15:0] OFS_EVT_STAT = 16'h00B0;
    localparam logic [15:0] OFS_EVT_MASK = 16'h00B2;
    // priority reset patterns
    localparam logic [15:0] RST_PRI_2222 = 16'h2222;
    localparam logic [15:0] RST_PRI_4444 = 16'h4444;
    localparam logic [15:0] RST_PRI_6 = 16'h2202;
    localparam logic [15:0] RST_PRI_9 = 16'h4044;
    localparam logic [15:0] RST_PRI_10 = 16'h4004;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // writable masks; reserved bits read zero, except bits 13 and 9 of priority word 6 until its first write
    localparam logic [15:0] MSK_PRI = 16'h7777;
    localparam logic [15:0] MSK_PRI_6 = 16'h0077;
    localparam logic [15:0] MSK_PRI_9 = 16'h7077;
    localparam logic [15:0] MSK_PRI_10 = 16'h7007;
    localparam logic [15:0] MSK_CTRL_TWO = 16'hC007;
    localparam logic [15:0] MSK_CTRL_ONE = 16'h871E;
    localparam logic [15:0] MSK_FLAGS_1 = 16'h03FF;
    localparam logic [15:0] MSK_FLAGS_2 = 16'h0980;
    // field positions
    localparam int POL_ZERO_BIT = 0;
    localparam int POL_TWO_BIT = 2;
    localparam int ALT_VEC_BIT = 15;
    localparam int NEST_DIS_BIT = 15;
    localparam int EXT0_FLAG_POS = 0;        // flags word 0 bit 0
    localparam int EXT1_FLAG_POS = 16;       // flags word 1 bit 0
    localparam int EXT2_FLAG_POS = 23;       // flags word 1 bit 7
    // event status bits
    localparam int EVT_EXT0 = 0;
    localparam int EVT_WAKE = 3;
    localparam int EVT_SHADOW_OVR = 4;
    localparam int EVT_W = 5;
    localparam logic [2:0] PRI_NONE = 3'h0;
    // shadowed core context
    typedef struct packed {
        logic digit_carry_flag;
        logic negative_flag;
        logic overflow_flag;
        logic zero_flag;
        logic carry_flag;
        logic [15:0] working_reg_zero;
        logic [15:0] working_reg_one;
        logic [15:0] working_reg_two;
        logic [15:0] working_reg_three;
    } core_context_t;
    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} pwr_state_t;
endpackage : irq_pkg

/* verilog/edge_detect.sv */
/*
 * one external request input: two-stage synchroniser and a polarity
 * selectable edge detector that emits a single-cycle pulse.
 * assumes the request pin is asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module edge_detect
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_pin,
    input wire logic falling_sel,
    output logic edge_pulse
);
    logic meta_reg;      // first stage, read only by sync_reg
    logic sync_reg;      // settled level
    logic last_reg;      // previous settled level

    // synchroniser and history
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= req_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // a transition only, never a level; polarity picks direction
    always_comb
    begin
        if (falling_sel)
            edge_pulse = last_reg & ~sync_reg;
        else
            edge_pulse = ~last_reg & sync_reg;
    end
endmodule : edge_detect

/* verilog/irq_ctrl.sv */
/*
 * interrupt controller slice: register map, flag/enable/priority logic,
 * external edge requests, wake from sleep or idle, one-level shadow store.
 * assumes the core drives save/restore strobes from its shadow instructions
 * and gives acknowledge when it vectors.
 */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module irq_ctrl
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire irq_pkg::reg_req_t bus_req,
    output logic [15:0] rd_data,
    input wire logic [2:0] ext_request,
    input wire logic [2:0] core_priority_level,
    input wire logic sleep_enter,
    input wire logic idle_enter,
    input wire logic irq_ack,
    input wire logic shadow_save,
    input wire logic shadow_restore,
    input wire irq_pkg::core_context_t live_context,
    output irq_pkg::core_context_t shadow_context,
    output logic irq_request,
    output logic [5:0] irq_vector,
    output logic [2:0] irq_level,
    output logic alternate_vector_select,
    output logic nesting_disable,
    output logic core_wake,
    output logic core_asleep,
    output logic event_irq
);
    import irq_pkg::*;

    logic [15:0] ctrl_one_reg;              // control one
    logic [15:0] ctrl_two_reg;              // control two
    logic [NUM_SRC-1:0] flag_reg;           // three flag words
    logic [NUM_SRC-1:0] en_reg;             // three enable words
    logic [15:0] pri_reg [0:11];            // priority words
    logic [EVT_W-1:0] evt_stat_reg;         // sticky events
    logic [EVT_W-1:0] evt_mask_reg;         // event mask
    logic shadow_full_reg;                  // shadow holds unrestored save
    pwr_state_t pwr_reg;                    // core power state
    core_context_t shadow_reg;              // single-level store
    logic [2:0] ext_edge;                   // one-cycle edge pulses
    logic [NUM_SRC-1:0] ext_set;            // flag set vector
    logic [NUM_SRC-1:0] wr_flag_val;        // flag words as written
    logic [NUM_SRC-1:0] wr_flag_sel;        // which flag word is written
    logic [NUM_SRC-1:0] pending;            // flag and enable
    logic [2:0] best_pri;
    logic [5:0] best_src;
    logic [15:0] rd_next;
    logic wake_evt;
    logic wr;

    assign wr = bus_req.wr;

    // three edge detectors, one per external request
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ext
            edge_detect u_edge
            (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .req_pin(ext_request[gi]),
                .falling_sel(ctrl_two_reg[POL_ZERO_BIT + gi]),
                .edge_pulse(ext_edge[gi])
            );
        end
    endgenerate

    // edges map to their flag positions
    always_comb
    begin
        ext_set = '0;
        ext_set[EXT0_FLAG_POS] = ext_edge[0];
        ext_set[EXT1_FLAG_POS] = ext_edge[1];
        ext_set[EXT2_FLAG_POS] = ext_edge[2];
    end

    // decode a bus write to the flag words
    always_comb
    begin
        wr_flag_val = {bus_req.wdata & MSK_FLAGS_2,
            bus_req.wdata & MSK_FLAGS_1, bus_req.wdata};
        wr_flag_sel = '0;
        if (wr && bus_req.addr == OFS_FLAGS_0)
            wr_flag_sel[15:0] = '1;
        if (wr && bus_req.addr == OFS_FLAGS_1)
            wr_flag_sel[31:16] = '1;
        if (wr && bus_req.addr == OFS_FLAGS_2)
            wr_flag_sel[47:32] = '1;
    end

    // flags: software writes, hardware edges win over a clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            flag_reg <= '0;
        else
            flag_reg <= ((flag_reg & ~wr_flag_sel)
                | (wr_flag_val & wr_flag_sel)) | ext_set;
    end

    // enables and control registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            en_reg <= '0;
            ctrl_one_reg <= RST_ZERO;
            ctrl_two_reg <= RST_ZERO;
        end
        else if (wr)
        begin
            unique case (bus_req.addr)
                OFS_EN_0: en_reg[15:0] <= bus_req.wdata;
                OFS_EN_1: en_reg[31:16] <= bus_req.wdata & MSK_FLAGS_1;
                OFS_EN_2: en_reg[47:32] <= bus_req.wdata & MSK_FLAGS_2;
                OFS_CTRL_ONE: ctrl_one_reg <= bus_req.wdata & MSK_CTRL_ONE;
                OFS_CTRL_TWO: ctrl_two_reg <= bus_req.wdata & MSK_CTRL_TWO;
                default: ;                      // other or unmapped
            endcase
        end
    end

    // priority words; reserved words stay zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pri_reg[0] <= RST_PRI_2222;
            pri_reg[1] <= RST_PRI_4444;
            pri_reg[2] <= RST_PRI_2222;
            pri_reg[3] <= RST_PRI_2222;
            pri_reg[4] <= RST_PRI_4444;
            pri_reg[5] <= RST_PRI_4444;
            pri_reg[6] <= RST_PRI_6;
            pri_reg[7] <= RST_ZERO;
            pri_reg[8] <= RST_ZERO;
            pri_reg[9] <= RST_PRI_9;
            pri_reg[10] <= RST_PRI_10;
            pri_reg[11] <= RST_ZERO;
        end
        else if (wr)
        begin
            unique case (bus_req.addr)
                OFS_PRI_0: pri_reg[0] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_1: pri_reg[1] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_2: pri_reg[2] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_3: pri_reg[3] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_4: pri_reg[4] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_5: pri_reg[5] <= bus_req.wdata & MSK_PRI;
                OFS_PRI_6: pri_reg[6] <= bus_req.wdata & MSK_PRI_6;
                OFS_PRI_9: pri_reg[9] <= bus_req.wdata & MSK_PRI_9;
                OFS_PRI_10: pri_reg[10] <= bus_req.wdata & MSK_PRI_10;
                default: ;                      // reserved words ignore
            endcase
        end
    end

    // pending and arbitration: highest priority, lowest index on tie
    always_comb
    begin
        pending = flag_reg & en_reg;
        best_pri = PRI_NONE;
        best_src = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            // source i sits in word i/4, nibble i%4
            if (pending[i] &&
                pri_reg[i / 4][(i % 4) * 4 +: 3] >= best_pri &&
                pri_reg[i / 4][(i % 4) * 4 +: 3] != PRI_NONE)
            begin
                best_pri = pri_reg[i / 4][(i % 4) * 4 +: 3];
                best_src = 6'(i);
            end
        end
    end

    // request only strictly above the core level, asleep or not
    assign irq_request = (best_pri > core_priority_level);
    assign irq_vector = best_src;
    assign irq_level = best_pri;
    // wake in the same cycle the request is presented
    assign wake_evt = irq_request && pwr_reg != PWR_RUN;
    assign core_wake = wake_evt;
    assign core_asleep = (pwr_reg != PWR_RUN);
    assign alternate_vector_select = ctrl_two_reg[ALT_VEC_BIT];
    assign nesting_disable = ctrl_one_reg[NEST_DIS_BIT];

    // power state; request or acknowledge returns to run
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pwr_reg <= PWR_RUN;
        else
        begin
            unique case (pwr_reg)
                PWR_RUN:
                begin
                    if (sleep_enter)
                        pwr_reg <= PWR_SLEEP;
                    else if (idle_enter)
                        pwr_reg <= PWR_IDLE;
                end
                PWR_SLEEP, PWR_IDLE:
                begin
                    if (wake_evt || irq_ack)
                        pwr_reg <= PWR_RUN;
                end
                default: pwr_reg <= PWR_RUN;    // illegal code recovers
            endcase
        end
    end

    // shadow store: only the save strobe loads it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            shadow_reg <= '0;
            shadow_full_reg <= 1'b0;
        end
        else if (shadow_save)
        begin
            shadow_reg <= live_context;
            shadow_full_reg <= 1'b1;
        end
        else if (shadow_restore)
            shadow_full_reg <= 1'b0;
    end

    // restore path is the only way out; no register offset maps it
    assign shadow_context = shadow_reg;

    // sticky events; set wins over write-one-to-clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            evt_stat_reg <= '0;
            evt_mask_reg <= '0;
        end
        else
        begin
            evt_stat_reg <= (evt_stat_reg & ~((wr &&
                bus_req.addr == OFS_EVT_STAT) ? bus_req.wdata[EVT_W-1:0]
                : '0)) | {shadow_save & shadow_full_reg, wake_evt,
                ext_edge};
            if (wr && bus_req.addr == OFS_EVT_MASK)
                evt_mask_reg <= bus_req.wdata[EVT_W-1:0];
        end
    end

    assign event_irq = |(evt_stat_reg & evt_mask_reg);

    // read mux
    always_comb
    begin
        rd_next = RST_ZERO;
        unique case (bus_req.addr)
            OFS_CTRL_ONE: rd_next = ctrl_one_reg;
            OFS_CTRL_TWO: rd_next = ctrl_two_reg;
            OFS_FLAGS_0: rd_next = flag_reg[15:0];
            OFS_FLAGS_1: rd_next = flag_reg[31:16];
            OFS_FLAGS_2: rd_next = flag_reg[47:32];
            OFS_EN_0: rd_next = en_reg[15:0];
            OFS_EN_1: rd_next = en_reg[31:16];
            OFS_EN_2: rd_next = en_reg[47:32];
            OFS_PRI_0: rd_next = pri_reg[0];
            OFS_PRI_1: rd_next = pri_reg[1];
            OFS_PRI_2: rd_next = pri_reg[2];
            OFS_PRI_3: rd_next = pri_reg[3];
            OFS_PRI_4: rd_next = pri_reg[4];
            OFS_PRI_5: rd_next = pri_reg[5];
            OFS_PRI_6: rd_next = pri_reg[6];
            OFS_PRI_9: rd_next = pri_reg[9];
            OFS_PRI_10: rd_next = pri_reg[10];
            OFS_EVT_STAT: rd_next = {11'h000, evt_stat_reg};
            OFS_EVT_MASK: rd_next = {11'h000, evt_mask_reg};
            default: rd_next = RST_ZERO;        // unmapped and reserved
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rd_data <= RST_ZERO;
        else if (bus_req.rd)
            rd_data <= rd_next;
        else
            rd_data <= RST_ZERO;
    end
endmodule : irq_ctrl

/* verif/irq_ctrl_monitor.sv */
/*
 * checker for the interrupt controller: shadow capture, request level,
 * low-power entry and wake.
 * assumes it is bound to irq_ctrl and sees one clock domain.
 */
`timescale 1ns/1ps
module irq_ctrl_monitor
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] core_priority_level,
    input wire logic sleep_enter,
    input wire logic idle_enter,
    input wire logic irq_ack,
    input wire logic shadow_save,
    input wire irq_pkg::core_context_t live_context,
    input wire irq_pkg::core_context_t shadow_context,
    input wire logic irq_request,
    input wire logic [2:0] irq_level,
    input wire logic core_wake,
    input wire logic core_asleep
);
    import irq_pkg::*;
    // one domain, so one clock and one reset for all
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // wake is seen, then low power is left one cycle later
    sequence s_wake;
        core_wake ##1 !core_asleep;
    endsequence
    // a quiet entry into sleep or idle
    sequence s_enter;
        (sleep_enter || idle_enter) && !irq_request && !irq_ack;
    endsequence
    property p_save_copy;
        shadow_save |=> shadow_context == $past(live_context);
    endproperty
    a_save_copy: assert property (p_save_copy)
        else $error("shadow missed the live context");
    property p_shadow_hold;
        !shadow_save |=> $stable(shadow_context);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold)
        else $error("shadow changed without a save");
    property p_above;
        irq_request |-> irq_level > core_priority_level;
    endproperty
    a_above: assert property (p_above)
        else $error("request not above core level");
    property p_nonzero;
        irq_request |-> irq_level != PRI_NONE;
    endproperty
    a_nonzero: assert property (p_nonzero)
        else $error("request at priority zero");
    property p_wake;
        core_asleep && irq_request |-> s_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("request did not wake the core");
    property p_wake_cause;
        core_wake |-> irq_request && core_asleep;
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake without a request");
    property p_enter;
        s_enter |=> core_asleep;
    endproperty
    a_enter: assert property (p_enter)
        else $error("low power not entered");
    property p_stay;
        core_asleep && !irq_request && !irq_ack |=> core_asleep;
    endproperty
    a_stay: assert property (p_stay)
        else $error("left low power with no cause");
endmodule : irq_ctrl_monitor

bind irq_ctrl irq_ctrl_monitor u_monitor
(
    .sys_clk(sys_clk), .rst_n(rst_n),
    .core_priority_level(core_priority_level),
    .sleep_enter(sleep_enter), .idle_enter(idle_enter), .irq_ack(irq_ack),
    .shadow_save(shadow_save), .live_context(live_context),
    .shadow_context(shadow_context), .irq_request(irq_request),
    .irq_level(irq_level), .core_wake(core_wake), .core_asleep(core_asleep)
);

/* verif/core_model.sv */
/*
 * processor core partner: turns bench commands into one-cycle pulses and
 * holds the core level and live context one edge behind the bench.
 * assumes cmd bits: 0 sleep, 1 idle, 2 save, 3 restore, 4 ack, 5 nested.
 */
`timescale 1ns/1ps
module core_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [5:0] cmd,
    input wire logic [2:0] level_in,
    input wire irq_pkg::core_context_t ctx_in,
    output logic [2:0] core_priority_level,
    output logic sleep_enter,
    output logic idle_enter,
    output logic shadow_save,
    output logic shadow_restore,
    output logic irq_ack,
    output irq_pkg::core_context_t live_context
);
    import irq_pkg::*;
    logic busy_reg; // a handler already owns the shadow
    // pulses; a nested save only when the bench insists on misuse
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            {irq_ack, shadow_restore, idle_enter, sleep_enter} <= 4'h0;
            shadow_save <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            {irq_ack, shadow_restore} <= cmd[4:3];
            {idle_enter, sleep_enter} <= cmd[1:0];
            shadow_save <= cmd[2] && (!busy_reg || cmd[5]);
            busy_reg <= (busy_reg || cmd[2]) && !cmd[3];
        end
    end
    // level and context follow the bench one edge later
    always_ff @(posedge sys_clk)
    begin
        core_priority_level <= rst_n ? level_in : 3'h0;
        live_context <= rst_n ? ctx_in : '0;
    end
endmodule : core_model

/* verif/tb_irq_ctrl.sv */
/*
 * self-checking bench: register map, edge requests, priority, wake and
 * shadow store, event interrupt.
 * assumes irq_pkg, irq_ctrl, core_model and the bound monitor.
 */
`timescale 1ns/1ps
module tb_irq_ctrl;
    import irq_pkg::*;
    logic sys_clk = 1'b0; // 100 ns period
    logic rst_n = 1'b0;
    reg_req_t bus_req = '0;
    logic [2:0] ext_request = 3'h0;
    logic [2:0] level_in = 3'h0; // core level asked of the model
    logic [5:0] cmd = 6'h00;
    core_context_t ctx_in = '0;
    core_context_t live_context, shadow_context;
    logic [15:0] rd_data;
    logic [5:0] irq_vector;
    logic [2:0] core_priority_level, irq_level;
    logic sleep_enter, idle_enter, irq_ack, shadow_save, shadow_restore;
    logic irq_request, core_wake, core_asleep, event_irq, alt_sel, nest_dis;
    int err_total = 0;
    int n_compared = 0;
    localparam core_context_t CTX_A = {5'h15, 64'h1111_2222_3333_4444};
    localparam core_context_t CTX_B = {5'h0A, 64'hAAAA_5555_0F0F_F0F0};
    // reset image: address, value; 0x0050 is unmapped
    localparam logic [31:0] RESET_MAP [19] = '{
        32'h0082_0000, 32'h0084_0000, 32'h0086_0000, 32'h0088_0000,
        32'h008C_0000, 32'h3800_0000, 32'h0600_0000, 32'h0800_0000,
        32'h0094_2222, 32'h9600_4444, 32'h8600_2222, 32'hA600_2222,
        32'h009C_4444, 32'h009E_4444, 32'h00A0_2202, 32'h00A2_0000,
        32'h00A6_4044, 32'h00A8_4004, 32'h0050_0000};

    always #50 sys_clk = ~sys_clk;

    irq_ctrl uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data(rd_data), .ext_request(ext_request),
        .core_priority_level(core_priority_level),
        .sleep_enter(sleep_enter), .idle_enter(idle_enter),
        .irq_ack(irq_ack), .shadow_save(shadow_save),
        .shadow_restore(shadow_restore), .live_context(live_context),
        .shadow_context(shadow_context), .irq_request(irq_request),
        .irq_vector(irq_vector), .irq_level(irq_level),
        .alternate_vector_select(alt_sel), .nesting_disable(nest_dis),
        .core_wake(core_wake), .core_asleep(core_asleep),
        .event_irq(event_irq)
    );

    core_model partner
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .level_in(level_in),
        .ctx_in(ctx_in), .core_priority_level(core_priority_level),
        .sleep_enter(sleep_enter), .idle_enter(idle_enter),
        .shadow_save(shadow_save), .shadow_restore(shadow_restore),
        .irq_ack(irq_ack), .live_context(live_context)
    );

    // count, and report a mismatch at once
    task chk(input string nm, input logic [68:0] e, input logic [68:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // one-cycle write strobe
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 chk($sformatf("reg %h", a), 69'(e), 69'(rd_data));
    endtask : rd

    task pulse(input logic [5:0] c);
        @(posedge sys_clk);
        cmd <= c;
        @(posedge sys_clk);
        cmd <= 6'h00;
    endtask : pulse

    task set_level(input logic [2:0] l);
        @(posedge sys_clk);
        level_in <= l;
        tick(3);
    endtask : set_level

    task print_verdict;
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // the whole run takes well under a thousand cycles
    initial
    begin
        #(5000 * 100);
        err_total++;
        print_verdict();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (RESET_MAP[i])
            rd(RESET_MAP[i][31:16], RESET_MAP[i][15:0]);
        wr(OFS_PRI_8, 16'hFFFF);
        rd(OFS_PRI_8, 16'h0000);
        wr(OFS_EN_0, 16'h0001);
        wr(OFS_EN_1, 16'h0081);
        // rising edges on each input; ties go to the lower index
        for (int i = 0; i < 3; i++)
        begin
            @(posedge sys_clk);
            ext_request[i] <= 1'b1;
            tick(5);
            chk("vector", 69'(i ? 16 : 0), 69'(irq_vector));
            chk("level", 69'(i ? 4 : 2), 69'(irq_level));
            rd(i ? OFS_FLAGS_1 : OFS_FLAGS_0,
               i == 2 ? 16'h0081 : 16'h0001);
        end
        // steady high pins must not set the flags again
        wr(OFS_FLAGS_0, 16'h0000);
        wr(OFS_FLAGS_1, 16'h0000);
        tick(5);
        chk("irq_request", 69'(1'b0), 69'(irq_request));
        wr(OFS_CTRL_TWO, 16'h8001);
        rd(OFS_CTRL_TWO, 16'h8001);
        chk("alt_sel", 69'(1'b1), 69'(alt_sel));
        // control one: writable bits only, nesting switch shows
        wr(OFS_CTRL_ONE, 16'hFFFF);
        rd(OFS_CTRL_ONE, 16'h871E);
        chk("nest_dis", 69'(1'b1), 69'(nest_dis));
        @(posedge sys_clk);
        ext_request <= 3'h0;
        tick(5);
        rd(OFS_FLAGS_0, 16'h0001);
        rd(OFS_FLAGS_1, 16'h0000);
        wr(OFS_EN_0, 16'h0000);
        tick(1);
        chk("irq_request", 69'(1'b0), 69'(irq_request));
        wr(OFS_EN_0, 16'h0001);
        set_level(3'h2);
        chk("irq_request", 69'(1'b0), 69'(irq_request));
        set_level(3'h1);
        chk("irq_request", 69'(1'b1), 69'(irq_request));
        wr(OFS_PRI_0, 16'hFFFF);
        rd(OFS_PRI_0, 16'h7777);
        chk("level", 69'(3'h7), 69'(irq_level));
        set_level(3'h7);
        // sleep, idle, then sleep left by an acknowledge
        for (int k = 0; k < 3; k++)
        begin
            pulse(k == 1 ? 6'h02 : 6'h01);
            tick(2);
            chk("asleep", 69'(1'b1), 69'(core_asleep));
            chk("wake", 69'(1'b0), 69'(core_wake));
            if (k == 2)
                pulse(6'h10);
            else
                set_level(3'h0);
            tick(2);
            chk("asleep", 69'(1'b0), 69'(core_asleep));
            chk("irq_request", 69'(k < 2), 69'(irq_request));
            set_level(3'h7);
        end
        @(posedge sys_clk);
        ctx_in <= CTX_A;
        pulse(6'h04);
        tick(2);
        chk("shadow", CTX_A, shadow_context);
        @(posedge sys_clk);
        ctx_in <= CTX_B;
        pulse(6'h24);
        tick(2);
        chk("shadow", CTX_B, shadow_context);
        @(posedge sys_clk);
        ctx_in <= CTX_A;
        pulse(6'h08);
        tick(4);
        chk("shadow", CTX_B, shadow_context);
        // edges, wake and the overwrite are all sticky
        rd(OFS_EVT_STAT, 16'h001F);
        chk("event_irq", 69'(1'b0), 69'(event_irq));
        wr(OFS_EVT_MASK, 16'h0010);
        tick(1);
        chk("event_irq", 69'(1'b1), 69'(event_irq));
        wr(OFS_EVT_STAT, 16'h0010);
        tick(1);
        chk("event_irq", 69'(1'b0), 69'(event_irq));
        rd(OFS_EVT_STAT, 16'h000F);
        print_verdict();
    end
endmodule : tb_irq_ctrl
